// *** rtl/flash_pin_pkg.sv ***
// Constants shared by the serial flash pin front end
package flash_pin_pkg;
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] DUAL_LAST = 3'h3;
    localparam logic [7:0] TX_RESET = 8'h00;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_BUSY_WAIT
    } power_state_type;
endpackage

// *** rtl/flash_pin_frontend.sv ***
// Serial pin front end: framing, bit capture, single and dual output shifting
`timescale 1ns/10ps
`default_nettype none
module flash_pin_frontend (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    output logic si_out,
    output logic si_oe_out,
    output logic so_out,
    output logic so_oe_out,
    input wire logic [7:0] tx_byte_in,
    input wire logic dual_mode_in,
    output logic tx_load_out,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic frame_start_out,
    output logic frame_end_out,
    input wire logic busy_in,
    output logic standby_out
);
    // Three-stage synchronisers; stage 0 feeds only stage 1
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [2:0] si_sync;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_sync <= 3'h7;
            sck_sync <= 3'h0;
            si_sync <= 3'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], cs_n_in};
            sck_sync <= {sck_sync[1:0], sck_in};
            si_sync <= {si_sync[1:0], si_in};
        end
    end

    // Filtered levels: change counts once stages one and two agree
    logic cs_lvl;
    logic sck_lvl;
    logic next_cs_lvl;
    logic next_sck_lvl;
    always_comb begin
        next_cs_lvl = cs_lvl;
        next_sck_lvl = sck_lvl;
        if (cs_sync[1] == cs_sync[2]) begin
            next_cs_lvl = cs_sync[2];
        end
        if (sck_sync[1] == sck_sync[2]) begin
            next_sck_lvl = sck_sync[2];
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_lvl <= 1'b1;
            sck_lvl <= 1'b0;
        end else begin
            cs_lvl <= next_cs_lvl;
            sck_lvl <= next_sck_lvl;
        end
    end

    // Edge events; clock edges count only inside a frame
    logic selected;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign selected = ~cs_lvl;
    assign cs_fall = cs_lvl & ~next_cs_lvl;
    assign cs_rise = ~cs_lvl & next_cs_lvl;
    // either idle level; only edges seen while selected count, so mode 3's first fall sends bit 7
    assign sck_rise = selected & ~next_cs_lvl & ~sck_lvl & next_sck_lvl;
    assign sck_fall = selected & ~next_cs_lvl & sck_lvl & ~next_sck_lvl;

    // Receive shifter and frame flags
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] next_rx_shift;
    logic [2:0] next_rx_cnt;
    logic [7:0] next_rx_byte;
    logic next_rx_valid;
    always_comb begin
        next_rx_shift = rx_shift;
        next_rx_cnt = rx_cnt;
        next_rx_byte = rx_byte_out;
        next_rx_valid = 1'b0;
        if (cs_fall) begin
            next_rx_cnt = 3'h0;
        end else if (sck_rise && !dual_mode_in) begin
            next_rx_shift = {rx_shift[6:0], si_sync[2]};
            next_rx_cnt = rx_cnt + 3'h1;
            if (rx_cnt == flash_pin_pkg::BIT_LAST) begin
                next_rx_byte = {rx_shift[6:0], si_sync[2]};
                next_rx_valid = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_shift <= flash_pin_pkg::TX_RESET;
            rx_cnt <= 3'h0;
            rx_byte_out <= flash_pin_pkg::TX_RESET;
            rx_valid_out <= 1'b0;
            frame_start_out <= 1'b0;
            frame_end_out <= 1'b0;
        end else begin
            rx_shift <= next_rx_shift;
            rx_cnt <= next_rx_cnt;
            rx_byte_out <= next_rx_byte;
            rx_valid_out <= next_rx_valid;
            frame_start_out <= cs_fall;
            frame_end_out <= cs_rise;
        end
    end

    // Transmit shifter: one bit per falling edge, or two in dual mode
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;
    logic lane0;
    logic lane1;
    logic drive_so;
    logic drive_si;
    logic [7:0] next_tx_shift;
    logic [2:0] next_tx_cnt;
    logic next_lane0;
    logic next_lane1;
    logic next_drive_so;
    logic next_drive_si;
    logic tx_load;
    always_comb begin
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        next_lane0 = lane0;
        next_lane1 = lane1;
        next_drive_so = drive_so;
        next_drive_si = drive_si;
        tx_load = 1'b0;
        if (cs_rise || !selected) begin
            next_drive_so = 1'b0;
            next_drive_si = 1'b0;
            next_tx_cnt = 3'h0;
        end else if (sck_fall) begin
            if (dual_mode_in) begin
                // lower lane on the input pin
                // upper lane on the output pin
                next_drive_so = 1'b1;
                next_drive_si = 1'b1;
                if (tx_cnt[1:0] == 2'h0) begin
                    next_lane1 = tx_byte_in[7];
                    next_lane0 = tx_byte_in[6];
                    next_tx_shift = {tx_byte_in[5:0], 2'h0};
                    tx_load = 1'b1;
                end else begin
                    next_lane1 = tx_shift[7];
                    next_lane0 = tx_shift[6];
                    next_tx_shift = {tx_shift[5:0], 2'h0};
                end
                next_tx_cnt = (tx_cnt[1:0] == flash_pin_pkg::DUAL_LAST[1:0]) ? 3'h0 : tx_cnt + 3'h1;
            end else begin
                next_drive_so = 1'b1;
                next_drive_si = 1'b0;
                if (tx_cnt == 3'h0) begin
                    next_lane1 = tx_byte_in[7];
                    next_tx_shift = {tx_byte_in[6:0], 1'b0};
                    tx_load = 1'b1;
                end else begin
                    next_lane1 = tx_shift[7];
                    next_tx_shift = {tx_shift[6:0], 1'b0};
                end
                next_tx_cnt = tx_cnt + 3'h1;
            end
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_shift <= flash_pin_pkg::TX_RESET;
            tx_cnt <= 3'h0;
            lane0 <= 1'b0;
            lane1 <= 1'b0;
            drive_so <= 1'b0;
            drive_si <= 1'b0;
        end else begin
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            lane0 <= next_lane0;
            lane1 <= next_lane1;
            drive_so <= next_drive_so;
            drive_si <= next_drive_si;
        end
    end
    assign so_out = lane1;
    assign so_oe_out = drive_so;
    assign si_out = lane0;
    assign si_oe_out = drive_si;
    assign tx_load_out = tx_load;

    // Power state: standby only once deselected and not busy
    flash_pin_pkg::power_state_type pstate;
    flash_pin_pkg::power_state_type next_pstate;
    always_comb begin
        next_pstate = pstate;
        case (pstate)
            flash_pin_pkg::ST_STANDBY: begin
                if (cs_fall) begin
                    next_pstate = flash_pin_pkg::ST_ACTIVE;
                end
            end
            flash_pin_pkg::ST_ACTIVE: begin
                if (cs_rise) begin
                    next_pstate = busy_in ? flash_pin_pkg::ST_BUSY_WAIT : flash_pin_pkg::ST_STANDBY;
                end
            end
            flash_pin_pkg::ST_BUSY_WAIT: begin
                if (cs_fall) begin
                    next_pstate = flash_pin_pkg::ST_ACTIVE;
                end else if (!busy_in) begin
                    next_pstate = flash_pin_pkg::ST_STANDBY;
                end
            end
            default: begin
                next_pstate = flash_pin_pkg::ST_STANDBY;
            end
        endcase
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pstate <= flash_pin_pkg::ST_STANDBY;
        end else begin
            pstate <= next_pstate;
        end
    end
    assign standby_out = (pstate == flash_pin_pkg::ST_STANDBY);

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    desel_float_a: assert property (cs_lvl && $past(cs_lvl) |-> !so_oe_out && !si_oe_out)
        else $error("output driven while deselected");
    no_capture_a: assert property (!selected |=> !rx_valid_out)
        else $error("bit captured while deselected");
    frame_pulse_a: assert property (frame_start_out |-> selected && $past(cs_lvl))
        else $error("frame start without select fall");
    busy_hold_a: assert property (busy_in && pstate != flash_pin_pkg::ST_STANDBY |=> !standby_out)
        else $error("standby entered while busy");
    rx_count_a: assert property (sck_rise && !dual_mode_in |=> rx_cnt == $past(rx_cnt) + 3'h1)
        else $error("rising edge not sampled");
    fall_drive_a: assert property (sck_fall |=> so_oe_out)
        else $error("no output after falling edge");
    dual_lane_a: assert property (sck_fall && dual_mode_in |=> si_oe_out && so_oe_out)
        else $error("dual lanes not driven");
    dual_upper_a: assert property (sck_fall && dual_mode_in && tx_cnt[1:0] == 2'h0
        |=> so_out == $past(tx_byte_in[7]) && si_out == $past(tx_byte_in[6]))
        else $error("dual lane data wrong");
    mode_any_a: assert property (cs_fall |=> rx_cnt == 3'h0)
        else $error("bit count not cleared at frame start");
    byte_c: cover property (rx_valid_out);
    dual_c: cover property (sck_fall && dual_mode_in);
    busy_c: cover property (pstate == flash_pin_pkg::ST_BUSY_WAIT ##1 standby_out);
endmodule // flash_pin_frontend
`default_nettype wire

// *** dv/spi_host_model.sv ***
// Behavioural SPI master host for the flash pin front end
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input wire logic mclk_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out,
    output logic si_en_out
);
    logic cpol = 1'h0;
    initial begin
        cs_n_out = 1'h1;
        sck_out = 1'h0;
        si_out = 1'h0;
        si_en_out = 1'h1;
    end
    // Every change lands a fixed delay after the mclk edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask
    // frame opens with clock at its idle level
    task automatic start(input logic mode3);
        cpol = mode3;
        sck_out = mode3;
        tick(4);
        cs_n_out = 1'h0;
        tick(6);
    endtask
    // Long tail so the last output bit is seen before release
    task automatic stop();
        tick(8);
        cs_n_out = 1'h1;
        tick(6);
        // take the line back only once the device has let go of it
        si_en_out = 1'h1;
    endtask
    // data set ahead of the rise, line let go when dual
    task automatic send(input logic [7:0] d, input int n, input logic dual);
        si_en_out = !dual;
        for (int i = 7; i > 7 - n; i--) begin
            if (cpol) sck_out = 1'h0;
            si_out = d[i];
            tick(4);
            sck_out = 1'h1;
            tick(4);
            if (!cpol) sck_out = 1'h0;
        end
    endtask
    // Even toggle count leaves the clock at its idle level
    task automatic noise(input logic [31:0] p);
        for (int i = 0; i < 16; i++) begin
            si_out = p[i];
            sck_out = !sck_out;
            tick(4);
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the flash pin front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [7:0] tx_byte_in = 8'h00;
    logic dual_mode_in = 1'h0;
    logic busy_in = 1'h0;
    logic cs_n, sck, host_si, host_en, io0, si_out, si_oe_out, so_out, so_oe_out;
    logic flip = 1'h0;
    logic tx_load_out, rx_valid_out, frame_start_out, frame_end_out, standby_out;
    logic [7:0] rx_byte_out;
    logic [31:0] seed = 32'h4d04f420;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    int fails = 0;
    int cmp_count = 0;
    int starts = 0;
    int ends = 0;
    int pos = 0;
    always #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) flip <= ~flip;
    // A released lane shows a toggling level, never a held one
    assign io0 = si_oe_out ? si_out : (host_en ? host_si : flip);
    spi_host_model host_u (.mclk_in(mclk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(host_si), .si_en_out(host_en));
    flash_pin_frontend dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(io0),
        .si_out(si_out), .si_oe_out(si_oe_out), .so_out(so_out), .so_oe_out(so_oe_out), .tx_byte_in(tx_byte_in),
        .dual_mode_in(dual_mode_in), .tx_load_out(tx_load_out), .rx_byte_out(rx_byte_out),
        .rx_valid_out(rx_valid_out), .frame_start_out(frame_start_out), .frame_end_out(frame_end_out),
        .busy_in(busy_in), .standby_out(standby_out));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check_bit(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d compared, %0d failed", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Model records each byte taken and offers a fresh random one
    always @(posedge mclk_in) begin
        if (tx_load_out) begin
            txq.push_back(tx_byte_in);
            seed = lfsr(seed);
            tx_byte_in <= #2 seed[7:0];
        end
        if (rx_valid_out) check_byte("rx_byte", rxq.size() != 0 ? rxq.pop_front() : ~rx_byte_out, rx_byte_out);
        starts += frame_start_out;
        ends += frame_end_out;
    end
    // Lanes are read just before the next fall could change them
    always @(negedge sck) if (!cs_n) begin
        repeat (7) @(negedge mclk_in);
        if (dual_mode_in) begin
            check_bit("io1", txq[0][7 - 2 * pos], so_out);
            check_bit("io0", txq[0][6 - 2 * pos], io0);
        end else check_bit("so", txq[0][7 - pos], so_out);
        check_bit("so_oe", 1'h1, so_oe_out);
        pos++;
        if (pos == (dual_mode_in ? 4 : 8)) begin
            pos = 0;
            void'(txq.pop_front());
        end
    end
    // Partial trailing bytes are never expected back
    task automatic frame(input logic m3, input logic dual, input int nb, input int last);
        dual_mode_in = dual;
        host_u.start(m3);
        for (int b = 0; b < nb; b++) begin
            seed = lfsr(seed);
            if (!dual && (b < nb - 1 || last == 8)) rxq.push_back(seed[7:0]);
            host_u.send(seed[7:0], dual ? 4 : (b < nb - 1 ? 8 : last), dual);
        end
        host_u.stop();
        pos = 0;
        txq.delete();
        dual_mode_in = 1'h0;
    endtask
    initial begin
        repeat (50000) @(posedge mclk_in);
        fails++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        #2 rst_in = 1'h0;
        host_u.tick(4);
        check_bit("standby", 1'h1, standby_out);
        host_u.noise(lfsr(seed));
        for (int m = 0; m < 4; m++) frame(m[0], m[1], 2, 8);
        frame(1'h0, 1'h0, 2, 3);
        check_bit("so_oe_idle", 1'h0, so_oe_out);
        check_bit("io0_oe_idle", 1'h0, si_oe_out);
        check_bit("standby_idle", 1'h1, standby_out);
        busy_in = 1'h1;
        frame(1'h1, 1'h0, 1, 8);
        host_u.tick(10);
        check_bit("standby_busy", 1'h0, standby_out);
        busy_in = 1'h0;
        host_u.tick(4);
        check_bit("standby_done", 1'h1, standby_out);
        check_byte("starts", 8'h06, starts[7:0]);
        check_byte("ends", 8'h06, ends[7:0]);
        check_byte("rx_left", 8'h00, 8'(rxq.size()));
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
